// ---- src/frac_arith_pkg.sv ----
// fraction multiply, divide and shift-round datapath: shared types and constants
// assumes a sequencer on the same clock issuing one command at a time

package frac_arith_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // word layout: sign-magnitude, sign in the top bit
    localparam int WORD_W   = 16;
    localparam int FRAC_W   = 15;
    localparam int EXT_W    = 16;
    localparam int DBL_W    = 31;
    localparam int SIGN_POS = 15;
    localparam int CNT_W    = 6;

    ////////////////////////////////////////////////////////////////////////////
    // divide sequencing
    localparam logic [4:0] DIV_STEPS      = 5'h10;
    localparam logic [5:0] QUO_ALIGN_CNT  = 6'h0f;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and the largest fraction that rounding saturates to
    localparam logic [WORD_W-1:0] ACC_RST  = 16'h0000;
    localparam logic [EXT_W-1:0]  EXT_RST  = 16'h0000;
    localparam logic [FRAC_W-1:0] FRAC_MAX = 15'h7fff;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        OP_LOAD                 = 3'b000,
        OP_MULTIPLY             = 3'b001,
        OP_DIVIDE               = 3'b010,
        OP_SHIFT_RIGHT_DOUBLE   = 3'b011,
        OP_SHIFT_LEFT_AND_ROUND = 3'b100
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_DIVIDE = 2'b01
    } state_t;

    typedef struct packed {
        op_t               op;
        logic [WORD_W-1:0] operand;
        logic [CNT_W-1:0]  count;
    } cmd_t;

    typedef struct packed {
        state_t             state;
        logic [WORD_W-1:0]  acc;
        logic [EXT_W-1:0]   ext;
        logic               lsb_is_sign;
        logic               busy;
        logic               done;
        logic [EXT_W-1:0]   part_rem;
        logic [EXT_W-1:0]   dvd_low;
        logic [EXT_W-1:0]   quo;
        logic [FRAC_W-1:0]  divisor;
        logic               res_sign;
        logic [4:0]         steps;
    } arith_state_t;

endpackage

// ---- src/frac_arith.sv ----
// fraction multiply, divide and double-length shift datapath
// assumes commands come from logic on i_sys_clk and only while o_busy is low
`timescale 1ns/100ps

// Function
// - a multiply leaves sign plus a 31-bit fraction across accumulator and extension.
// - the last product fraction bit copies the sign and counts as zero.
// - shift-left-and-round shifts the double-length value left first, then rounds to 15 bits.
// - divide puts the shared sign in the accumulator sign, remainder beside it, quotient in ext.
// - the remainder lsb has the weight of the 31st dividend bit.
// - the first quotient bit has the weight of the first dividend bit.
// - double right shift moves accumulator bits into the extension.
// - shift-left-and-round by octal 17 after a divide aligns and rounds the quotient.
// - left shifts drop bits moved past the top fraction position.
module frac_arith
(
    input  wire logic                           i_sys_clk,
    input  wire logic                           i_reset_n,
    input  wire logic                           i_cmd_valid,
    input  wire frac_arith_pkg::cmd_t           i_cmd,
    output logic [frac_arith_pkg::WORD_W-1:0]   o_acc,
    output logic [frac_arith_pkg::EXT_W-1:0]    o_ext,
    output logic                                o_busy,
    output logic                                o_done
);

    ////////////////////////////////////////////////////////////////////////////
    frac_arith_pkg::arith_state_t r;
    frac_arith_pkg::arith_state_t next_r;

    logic [frac_arith_pkg::DBL_W-1:0]    dbl_field;
    logic [frac_arith_pkg::DBL_W-1:0]    dbl_masked;
    logic [frac_arith_pkg::DBL_W-1:0]    dbl_right;
    logic [frac_arith_pkg::DBL_W-1:0]    dbl_left;
    logic [frac_arith_pkg::FRAC_W-1:0]   rounded;
    logic [frac_arith_pkg::FRAC_W:0]     round_sum;
    logic [2*frac_arith_pkg::FRAC_W-1:0] product;
    logic                                prod_sign;
    logic [frac_arith_pkg::EXT_W-1:0]    trial;
    logic                                quo_bit;
    logic                                take;

    // a command while busy is dropped silently; the sequencer waits for done
    assign take = i_cmd_valid && !r.busy;

    ////////////////////////////////////////////////////////////////////////////
    // combinational datapath
    always_comb
    begin
        dbl_field = {r.acc[frac_arith_pkg::FRAC_W-1:0], r.ext};
        // the product's last bit is a sign echo, not data
        dbl_masked = dbl_field;
        if (r.lsb_is_sign)
        begin
            dbl_masked[0] = 1'b0;
        end
        // right shift and divide see the echo as zero too, so it can never
        // turn into a significant bit further down the chain
        dbl_right = dbl_masked >> i_cmd.count;
        dbl_left  = dbl_masked << i_cmd.count;
        round_sum = {1'b0, dbl_left[frac_arith_pkg::DBL_W-1:frac_arith_pkg::EXT_W]}
                  + {{frac_arith_pkg::FRAC_W{1'b0}}, dbl_left[frac_arith_pkg::EXT_W-1]};
        // carry out of the top bit would reach unity; hold at the largest fraction
        if (round_sum[frac_arith_pkg::FRAC_W])
        begin
            rounded = frac_arith_pkg::FRAC_MAX;
        end
        else
        begin
            rounded = round_sum[frac_arith_pkg::FRAC_W-1:0];
        end
        product   = r.acc[frac_arith_pkg::FRAC_W-1:0]
                  * i_cmd.operand[frac_arith_pkg::FRAC_W-1:0];
        prod_sign = r.acc[frac_arith_pkg::SIGN_POS] ^ i_cmd.operand[frac_arith_pkg::SIGN_POS];
        // restoring divide: bring down one dividend bit per step
        // trial is the remainder doubled plus the next dividend bit
        trial   = {r.part_rem[frac_arith_pkg::FRAC_W-1:0], r.dvd_low[frac_arith_pkg::EXT_W-1]};
        quo_bit = (trial >= {1'b0, r.divisor});
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        next_r      = r;
        next_r.done = 1'b0;
        case (r.state)
            frac_arith_pkg::ST_IDLE:
            begin
                if (take)
                begin
                    case (i_cmd.op)
                        frac_arith_pkg::OP_LOAD:
                        begin
                            // a load ends any pending sign echo
                            next_r.acc         = i_cmd.operand;
                            next_r.ext         = frac_arith_pkg::EXT_RST;
                            next_r.lsb_is_sign = 1'b0;
                            next_r.done        = 1'b1;
                        end
                        frac_arith_pkg::OP_MULTIPLY:
                        begin
                            next_r.acc = {prod_sign,
                                          product[2*frac_arith_pkg::FRAC_W-1:
                                                  frac_arith_pkg::FRAC_W]};
                            next_r.ext = {product[frac_arith_pkg::FRAC_W-1:0], prod_sign};
                            // the echo stays in the last extension bit until the next command with a defined op code
                            next_r.lsb_is_sign = 1'b1;
                            next_r.done        = 1'b1;
                        end
                        frac_arith_pkg::OP_DIVIDE:
                        begin
                            // no guard on the divisor: its size and nonzero value are the
                            // program's to assure, otherwise the quotient is meaningless
                            next_r.part_rem = {1'b0, r.acc[frac_arith_pkg::FRAC_W-1:0]};
                            next_r.dvd_low  = dbl_masked[frac_arith_pkg::EXT_W-1:0];
                            next_r.divisor  = i_cmd.operand[frac_arith_pkg::FRAC_W-1:0];
                            next_r.res_sign = prod_sign;
                            next_r.quo      = frac_arith_pkg::EXT_RST;
                            next_r.steps    = frac_arith_pkg::DIV_STEPS;
                            next_r.busy     = 1'b1;
                            next_r.state    = frac_arith_pkg::ST_DIVIDE;
                        end
                        frac_arith_pkg::OP_SHIFT_RIGHT_DOUBLE:
                        begin
                            // sign stays put; bits leaving the extension are lost
                            next_r.acc = {r.acc[frac_arith_pkg::SIGN_POS],
                                          dbl_right[frac_arith_pkg::DBL_W-1:
                                                    frac_arith_pkg::EXT_W]};
                            next_r.ext         = dbl_right[frac_arith_pkg::EXT_W-1:0];
                            next_r.lsb_is_sign = 1'b0;
                            next_r.done        = 1'b1;
                        end
                        frac_arith_pkg::OP_SHIFT_LEFT_AND_ROUND:
                        begin
                            // with count 15 after a divide the quotient lands by its sign
                            // other counts after a divide lose quotient high bits or leave
                            // remainder bits on top; the count is the program's to choose
                            next_r.acc = {r.acc[frac_arith_pkg::SIGN_POS], rounded};
                            next_r.ext         = frac_arith_pkg::EXT_RST;
                            next_r.lsb_is_sign = 1'b0;
                            next_r.done        = 1'b1;
                        end
                        default:
                        begin
                            // unknown op codes finish at once and change nothing
                            next_r.done = 1'b1;
                        end
                    endcase
                end
            end
            frac_arith_pkg::ST_DIVIDE:
            begin
                // one quotient bit per cycle: sixteen cycles traded for a single
                // subtractor instead of a full array divider
                if (quo_bit)
                begin
                    next_r.part_rem = trial - {1'b0, r.divisor};
                end
                else
                begin
                    next_r.part_rem = trial;
                end
                next_r.dvd_low = {r.dvd_low[frac_arith_pkg::EXT_W-2:0], 1'b0};
                next_r.quo     = {r.quo[frac_arith_pkg::EXT_W-2:0], quo_bit};
                next_r.steps   = r.steps - 5'h01;
                if (r.steps == 5'h01)
                begin
                    // remainder lsb keeps the weight of the last dividend bit
                    next_r.acc = {r.res_sign,
                                  next_r.part_rem[frac_arith_pkg::FRAC_W-1:0]};
                    next_r.ext = {r.quo[frac_arith_pkg::EXT_W-2:0], quo_bit};
                    next_r.lsb_is_sign = 1'b0;
                    next_r.busy        = 1'b0;
                    next_r.done        = 1'b1;
                    next_r.state       = frac_arith_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_r.state = frac_arith_pkg::ST_IDLE;
                next_r.busy  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register: async clear to constants, all else through next_r
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            r.state       <= frac_arith_pkg::ST_IDLE;
            r.acc         <= frac_arith_pkg::ACC_RST;
            r.ext         <= frac_arith_pkg::EXT_RST;
            r.lsb_is_sign <= 1'b0;
            r.busy        <= 1'b0;
            r.done        <= 1'b0;
            r.part_rem    <= frac_arith_pkg::EXT_RST;
            r.dvd_low     <= frac_arith_pkg::EXT_RST;
            r.quo         <= frac_arith_pkg::EXT_RST;
            r.divisor     <= '0;
            r.res_sign    <= 1'b0;
            r.steps       <= 5'h00;
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // every output is a state register bit, never logic
    assign o_acc  = r.acc;
    assign o_ext  = r.ext;
    assign o_busy = r.busy;
    assign o_done = r.done;

endmodule

// ---- sim/frac_arith_asserts.sv ----
// assertions on the fraction datapath ports
// assumes one clock and commands only while idle
`timescale 1ns/100ps
module frac_arith_asserts
(
    input wire logic                 i_sys_clk,
    input wire logic                 i_reset_n,
    input wire logic                 i_cmd_valid,
    input wire frac_arith_pkg::cmd_t i_cmd,
    input wire logic [15:0]          o_acc,
    input wire logic [15:0]          o_ext,
    input wire logic                 o_busy,
    input wire logic                 o_done
);
    default clocking dcb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    wire        take = i_cmd_valid && !o_busy;
    wire        mul  = take && i_cmd.op == frac_arith_pkg::OP_MULTIPLY;
    wire        div  = take && i_cmd.op == frac_arith_pkg::OP_DIVIDE;
    wire        shr  = take && i_cmd.op == frac_arith_pkg::OP_SHIFT_RIGHT_DOUBLE;
    wire        rnd  = take && i_cmd.op == frac_arith_pkg::OP_SHIFT_LEFT_AND_ROUND;
    wire [30:0] fld  = {o_acc[14:0], o_ext};
    logic       echo;
    // a product leaves its sign echo in the last bit, worth zero
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            echo <= 1'b0;
        else if (take && i_cmd.op <= frac_arith_pkg::OP_SHIFT_LEFT_AND_ROUND)
            echo <= mul;
    end
    wire [30:0] src  = fld & ~{30'h0, echo};
    ////////////////////////////////////////
    mul_sign_a:
    assert property (mul |=> o_done && o_acc[15] == ($past(o_acc[15]) ^ $past(i_cmd.operand[15])))
        else $error("bad product sign");
    sign_echo_a:
    assert property (mul |=> o_ext[0] == o_acc[15]) else $error("no sign echo");
    mul_value_a:
    assert property (mul |=> {o_acc[14:0], o_ext[15:1]} == $past(o_acc[14:0]) * $past(i_cmd.operand[14:0]))
        else $error("bad product");
    shr_value_a:
    assert property (shr |=> fld == ($past(src) >> $past(i_cmd.count)) && $stable(o_acc[15]))
        else $error("bad right shift");
    rnd_clear_a:
    assert property (rnd |=> o_ext == 16'h0000 && $stable(o_acc[15])) else $error("bad round");
    div_time_a:
    assert property (div |=> o_busy[*8] ##1 o_busy[*8] ##1 (o_done && !o_busy))
        else $error("bad divide timing");
    div_sign_a:
    assert property (div |-> ##17 o_acc[15] == ($past(o_acc[15], 17) ^ $past(i_cmd.operand[15], 17)))
        else $error("bad quotient sign");
    div_value_a:
    assert property (div |-> ##17 32'(o_ext) * $past(i_cmd.operand[14:0], 17) + o_acc[14:0]
        == $past(src, 17)) else $error("bad quotient or remainder");
    cover property (mul ##1 o_done);
    cover property (div ##17 o_done);
    cover property (rnd ##1 o_done);
    cover property (mul ##1 div);
endmodule
bind frac_arith frac_arith_asserts u_frac_arith_asserts (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_acc(o_acc),
    .o_ext(o_ext), .o_busy(o_busy), .o_done(o_done));

// ---- sim/frac_seq_model.sv ----
// sequencer model: issues one command, then waits for its completion
// assumes the datapath finishes any command within 40 cycles
`timescale 1ns/100ps
module frac_seq_model
(
    input  wire logic            i_sys_clk,
    input  wire logic            i_done,
    input  wire logic [15:0]     i_acc,
    input  wire logic [15:0]     i_ext,
    output frac_arith_pkg::cmd_t o_cmd,
    output logic                 o_cmd_valid,
    output logic                 o_stuck
);
    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd = '0;
        o_stuck = 1'b0;
    end
    task automatic issue(input frac_arith_pkg::op_t op, input logic [15:0] v, input logic [5:0] n);
        int k;
        k = 0;
        o_stuck = 1'b0;
        // the program never divides by zero or by a smaller magnitude
        if (op == frac_arith_pkg::OP_DIVIDE && {v[14:0], 16'h0000} <= {i_acc[14:0], i_ext})
            return;
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b1;
        o_cmd <= '{op, v, n};
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b0;
        // released lines show junk, never the old command
        o_cmd <= ~o_cmd;
        #1;
        while (!i_done && k < 40)
        begin
            @(posedge i_sys_clk);
            #1;
            k++;
        end
        o_stuck = !i_done;
    endtask
endmodule

// ---- sim/frac_arith_tb_top.sv ----
// self-checking bench for the fraction datapath
// assumes the sequencer model issues every command
`timescale 1ns/100ps
module frac_arith_tb_top;
    localparam frac_arith_pkg::op_t op_ld  = frac_arith_pkg::OP_LOAD;
    localparam frac_arith_pkg::op_t op_mul = frac_arith_pkg::OP_MULTIPLY;
    localparam frac_arith_pkg::op_t op_div = frac_arith_pkg::OP_DIVIDE;
    localparam frac_arith_pkg::op_t op_shr = frac_arith_pkg::OP_SHIFT_RIGHT_DOUBLE;
    localparam frac_arith_pkg::op_t op_rnd = frac_arith_pkg::OP_SHIFT_LEFT_AND_ROUND;
    logic                 clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 cmd_valid, busy, done, stuck, last_mul;
    logic [15:0]          acc, ext, m_acc, m_ext;
    frac_arith_pkg::cmd_t cmd;
    int                   error_cnt = 0;
    int                   checked = 0;
    always #2.5 clk = ~clk;
    frac_arith u_frac_arith (.i_sys_clk(clk), .i_reset_n(reset_n), .i_cmd_valid(cmd_valid),
        .i_cmd(cmd), .o_acc(acc), .o_ext(ext), .o_busy(busy), .o_done(done));
    frac_seq_model u_frac_seq_model (.i_sys_clk(clk), .i_done(done), .i_acc(acc), .i_ext(ext),
        .o_cmd(cmd), .o_cmd_valid(cmd_valid), .o_stuck(stuck));
    ////////////////////////////////////////
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(input frac_arith_pkg::op_t op, input logic [15:0] v, input logic [5:0] n);
        logic [30:0] f;
        logic [29:0] p;
        logic [15:0] r;
        // the sign echo of a product counts as zero for the command right after it
        f = {m_acc[14:0], m_ext} & ~{30'h0, last_mul};
        p = m_acc[14:0] * v[14:0];
        case (op)
            op_ld:  {m_acc, m_ext} = {v, 16'h0000};
            op_mul: {m_acc, m_ext} = {m_acc[15] ^ v[15], p, m_acc[15] ^ v[15]};
            op_div: {m_acc, m_ext} = {m_acc[15] ^ v[15], 15'(f % v[14:0]), 16'(f / v[14:0])};
            op_shr: {m_acc[14:0], m_ext} = f >> n;
            op_rnd:
            begin
                f = f << n;
                r = f[30:16] + f[15];
                {m_acc[14:0], m_ext} = {(r[15] ? frac_arith_pkg::FRAC_MAX : r[14:0]), 16'h0000};
            end
            default: ;
        endcase
        last_mul = op == op_mul;
        u_frac_seq_model.issue(op, v, n);
        cmp("completion stall", 16'h0000, {15'h0000, stuck});
        cmp("accumulator", m_acc, acc);
        cmp("extension", m_ext, ext);
    endtask
    task automatic t_mul;
        run(op_ld, 16'h4000, 6'h00);
        run(op_mul, 16'hc000, 6'h00);
        run(op_rnd, 16'h0000, 6'h00);
        run(op_ld, 16'h8001, 6'h00);
        run(op_mul, 16'h4000, 6'h00);
        run(op_rnd, 16'h0000, 6'h00);
        run(op_ld, 16'h7fff, 6'h00);
        run(op_mul, 16'h7fff, 6'h00);
        run(op_rnd, 16'h0000, 6'h02);
        run(op_ld, 16'h3000, 6'h00);
        run(op_mul, 16'ha000, 6'h00);
        run(op_div, 16'h4000, 6'h00);
        run(op_rnd, 16'h0000, frac_arith_pkg::QUO_ALIGN_CNT);
        $display("test mul done");
    endtask
    task automatic t_div;
        for (int k = 0; k < 3; k++)
        begin
            run(op_ld, k == 1 ? 16'hba5c : 16'h3a5c, 6'h00);
            run(op_shr, 16'h0000, 6'h05);
            run(op_div, k == 2 ? 16'h85a7 : 16'h05a7, 6'h00);
            run(op_rnd, 16'h0000, 6'h0e + 6'(k));
        end
        $display("test div done");
    endtask
    task automatic t_shift;
        logic [5:0] cs [6] = '{6'h00, 6'h01, 6'h10, 6'h1e, 6'h1f, 6'h3f};
        foreach (cs[k])
        begin
            run(op_ld, 16'hd6b3, 6'h00);
            run(op_shr, 16'h0000, cs[k]);
            run(op_rnd, 16'h0000, cs[k]);
        end
        $display("test shift done");
    endtask
    task automatic t_misc;
        run(op_ld, 16'h9234, 6'h00);
        for (int k = 5; k < 8; k++)
            run(frac_arith_pkg::op_t'(k[2:0]), 16'h7777, 6'h01);
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        #1;
        cmp("accumulator after reset", 16'h0000, acc);
        cmp("extension after reset", 16'h0000, ext);
        $display("test misc done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        m_acc = 16'h0000;
        m_ext = 16'h0000;
        last_mul = 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_mul;
        t_div;
        t_shift;
        t_misc;
        stop_test;
    end
    // about 170 cycles expected; 4000 cycles, over twenty times that, is a hang
    initial
    begin
        #20000;
        error_cnt++;
        stop_test;
    end
endmodule
